/* shared/cie_pkg.sv */
package cie_pkg;
   // ----------------------------------------
   // opcode layout
   // ----------------------------------------
   localparam int INSN_W = 14;   // instruction word width
   localparam int DATA_W = 8;    // data path width
   localparam int FADDR_W = 7;   // data register address width
   localparam int PC_W = 13;     // program counter width
   localparam int TGT_W = 11;    // call target field width
   localparam int PSC_W = 8;     // prescaler width
   localparam logic [13:0] OP_ACC_CLEAR = 14'h0103;   // accumulator clear opcode
   localparam logic [13:0] OP_WDOG_CLEAR = 14'h0064;  // watchdog clear opcode
   localparam logic [6:0] OP_FCLR_HI = 7'h03;         // upper seven bits of file clear
   localparam logic [2:0] OP_CALL_HI = 3'h4;          // upper three bits of call
   localparam logic [7:0] ZERO_BYTE = 8'h00;          // cleared data value
   localparam logic [12:0] PC_RESET = 13'h0000;       // program counter after reset
   // ----------------------------------------
   // call sequencing states, gray coded
   // ----------------------------------------
   typedef enum logic [0:0] {
      CIE_FIRST  = 1'b0,  // normal execute cycle
      CIE_SECOND = 1'b1   // second cycle of a call
   } cie_state_e;
endpackage : cie_pkg

/* rtl/cie_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
// watchdog counter and prescaler; cleared by the execute stage
module cie_watchdog
   import cie_pkg::*;
#(
   parameter int CNT_W = DATA_W,
   parameter int PS_W  = PSC_W
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             clkEn,
   // control
   input  wire logic             tick,
   input  wire logic             clearReq,
   // state
   output logic [CNT_W-1:0]      count_ff,
   output logic [PS_W-1:0]       prescale_ff
);
   // ----------------------------------------
   // prescaler then counter; clear beats tick
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prescale_ff <= '0;
         count_ff    <= '0;
      end else if (clkEn) begin
         if (clearReq) begin
            // a clear must not be undone by a same-cycle tick
            prescale_ff <= '0;
            count_ff    <= '0;
         end else if (tick) begin
            prescale_ff <= prescale_ff + 1'b1;
            if (&prescale_ff) begin
               count_ff <= count_ff + 1'b1;
            end
         end
      end
   end
endmodule : cie_watchdog
`default_nettype wire

/* rtl/cie_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// execute stage for clearing instructions and call
module cie_exec
   import cie_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   clkEn,
   // instruction from decode
   input  wire logic                   insnValid,
   input  wire logic [INSN_W-1:0]      insn,
   input  wire logic [PC_W-1:0]        insnAddr,
   input  wire logic [1:0]             pcUpper,
   // watchdog time base, same clock
   input  wire logic                   wdogTick,
   // register file write
   output logic                        fileWrEn_ff,
   output logic [FADDR_W-1:0]          fileWrAddr_ff,
   output logic [DATA_W-1:0]           fileWrData_ff,
   // core state
   output logic [DATA_W-1:0]           acc_ff,
   output logic                        zeroFlag_ff,
   output logic                        expiryStatusFlag_ff,
   output logic                        sleepEnteredFlag_ff,
   output logic [PC_W-1:0]             pc_ff,
   output logic [PC_W-1:0]             stackHead_ff,
   output logic                        stackPush_ff,
   output logic                        stall_ff,
   // watchdog state
   output logic [DATA_W-1:0]           watchdogCounter,
   output logic [PSC_W-1:0]            watchdogPrescale
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   cie_state_e state_ff;      // call sequencer
   logic       take;          // instruction accepted this cycle
   logic       isFileClr;     // file register clear op
   logic       isAccClr;      // accumulator clear op
   logic       isWdogClr;     // watchdog clear op
   logic       isCall;        // subroutine call

   // a second call cycle consumes no new instruction
   assign take      = clkEn && insnValid && (state_ff == CIE_FIRST);
   // opcode fields are cut from the top of the word by each pattern's width,
   // so a different word layout only needs new package constants
   // unknown opcodes are still taken and only move the program counter on
   assign isFileClr = take && (insn[INSN_W-1 -: $bits(OP_FCLR_HI)] == OP_FCLR_HI);
   assign isAccClr  = take && (insn == OP_ACC_CLEAR);
   assign isWdogClr = take && (insn == OP_WDOG_CLEAR);
   assign isCall    = take && (insn[INSN_W-1 -: $bits(OP_CALL_HI)] == OP_CALL_HI);

   // ----------------------------------------
   // call sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= CIE_FIRST;
      end else if (clkEn) begin
         case (state_ff)
            CIE_FIRST:  if (isCall) state_ff <= CIE_SECOND;
            CIE_SECOND: state_ff <= CIE_FIRST;
            // an illegal code falls back to the normal execute cycle
            default:    state_ff <= CIE_FIRST;
         endcase
      end
   end

   // stall tells fetch to hold during the call's second cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stall_ff <= 1'b0;
      end else if (clkEn) begin
         stall_ff <= isCall;
      end
   end

   // ----------------------------------------
   // program counter and stack head
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_ff        <= PC_RESET;
         stackHead_ff <= PC_RESET;
         stackPush_ff <= 1'b0;
      end else if (clkEn) begin
         stackPush_ff <= isCall;
         if (isCall) begin
            // return address is the call's own address plus one
            stackHead_ff <= insnAddr + 1'b1;
            pc_ff        <= {pcUpper, insn[TGT_W-1:0]};
         end else if (take) begin
            // plain step; the call's dead cycle leaves pc alone
            pc_ff <= insnAddr + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // register file write, one cycle
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fileWrEn_ff   <= 1'b0;
         fileWrAddr_ff <= '0;
         fileWrData_ff <= ZERO_BYTE;
      end else if (clkEn) begin
         fileWrEn_ff <= isFileClr;
         // address and data hold between strobes, so stale values are harmless
         if (isFileClr) begin
            fileWrAddr_ff <= insn[FADDR_W-1:0];
            fileWrData_ff <= ZERO_BYTE;
         end
      end
   end

   // ----------------------------------------
   // accumulator
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_ff <= ZERO_BYTE;
      end else if (clkEn && isAccClr) begin
         // nothing else loads the accumulator in this block
         acc_ff <= ZERO_BYTE;
      end
   end

   // ----------------------------------------
   // status flags; file and accumulator clears set zero, watchdog clear sets expiry and sleep
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         zeroFlag_ff <= 1'b0;
      end else if (clkEn && (isFileClr || isAccClr)) begin
         // only ever set here; clearing it belongs to other instructions
         zeroFlag_ff <= 1'b1;
      end
   end

   // reset and the watchdog clear both set these flags to one
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         expiryStatusFlag_ff <= 1'b1;
         sleepEnteredFlag_ff <= 1'b1;
      end else if (clkEn && isWdogClr) begin
         expiryStatusFlag_ff <= 1'b1;
         sleepEnteredFlag_ff <= 1'b1;
      end
   end

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   cie_watchdog #(
      .CNT_W (DATA_W),
      .PS_W  (PSC_W)
   ) i_cie_watchdog (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .clkEn       (clkEn),
      .tick        (wdogTick),
      .clearReq    (isWdogClr),
      .count_ff    (watchdogCounter),
      .prescale_ff (watchdogPrescale)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // file register clear
   a_fclr_zero_write: assert property (@(posedge clk_sys) disable iff (rst)
      isFileClr |=> fileWrEn_ff && fileWrData_ff == ZERO_BYTE && zeroFlag_ff)
      else $error("file clear did not write zero");
   a_fclr_addr: assert property (@(posedge clk_sys) disable iff (rst)
      isFileClr |=> fileWrAddr_ff == $past(insn[FADDR_W-1:0]))
      else $error("file clear address wrong");
   // expiry and sleep flags belong to the watchdog clear only
   a_fclr_flags_kept: assert property (@(posedge clk_sys) disable iff (rst)
      isFileClr |=> $stable(expiryStatusFlag_ff) && $stable(sleepEnteredFlag_ff))
      else $error("file clear touched other flags");
   // a lingering strobe would make the register file write twice
   a_fclr_one_cycle: assert property (@(posedge clk_sys) disable iff (rst)
      fileWrEn_ff && clkEn && !isFileClr |=> !fileWrEn_ff)
      else $error("file clear strobe held too long");

   // accumulator clear
   a_acc_clear: assert property (@(posedge clk_sys) disable iff (rst)
      isAccClr |=> acc_ff == ZERO_BYTE && zeroFlag_ff)
      else $error("accumulator clear failed");

   // watchdog clear
   a_wdog_count: assert property (@(posedge clk_sys) disable iff (rst)
      isWdogClr |=> watchdogCounter == '0)
      else $error("watchdog counter not cleared");
   a_wdog_flags: assert property (@(posedge clk_sys) disable iff (rst)
      isWdogClr |=> watchdogPrescale == '0 && expiryStatusFlag_ff && sleepEnteredFlag_ff)
      else $error("watchdog clear flags wrong");

   // call; a frozen enable may stretch the second cycle
   a_call_two_cycles: assert property (@(posedge clk_sys) disable iff (rst)
      isCall |=> (state_ff == CIE_SECOND && stall_ff)
         ##1 (state_ff == CIE_FIRST || !$past(clkEn)))
      else $error("call not two cycles");
   a_call_refused: assert property (@(posedge clk_sys) disable iff (rst)
      clkEn && state_ff == CIE_SECOND |=> !fileWrEn_ff && !stackPush_ff && !stall_ff)
      else $error("instruction taken in call dead cycle");
   a_call_stack: assert property (@(posedge clk_sys) disable iff (rst)
      isCall |=> stackHead_ff == $past(insnAddr) + 1'b1 && stackPush_ff)
      else $error("call return address wrong");
   a_call_pc: assert property (@(posedge clk_sys) disable iff (rst)
      isCall |=> pc_ff == {$past(pcUpper), $past(insn[TGT_W-1:0])})
      else $error("call target wrong");

   // coverage of the main scenarios
   c_fclr: cover property (@(posedge clk_sys) isFileClr);
   c_accclr: cover property (@(posedge clk_sys) isAccClr);
   c_wdog: cover property (@(posedge clk_sys) isWdogClr && wdogTick);
   c_call: cover property (@(posedge clk_sys) isCall ##2 take);
endmodule : cie_exec
`default_nettype wire

/* test/test_clear_instruction_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module test_clear_instruction_execute;
   import cie_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic                clk_sys = 1'b0;  // 40 MHz core clock
   logic                rst = 1'b1;      // async reset, high
   logic                clkEn = 1'b1;    // advance enable
   logic                insnValid = 1'b0;
   logic [INSN_W-1:0]   insn = '0;
   logic [PC_W-1:0]     insnAddr = '0;
   logic [1:0]          pcUpper = '0;
   logic                wdogTick = 1'b0;
   logic                fileWrEn_ff, zeroFlag_ff, expiryStatusFlag_ff, sleepEnteredFlag_ff;
   logic                stackPush_ff, stall_ff;
   logic [FADDR_W-1:0]  fileWrAddr_ff;
   logic [DATA_W-1:0]   fileWrData_ff, acc_ff, watchdogCounter;
   logic [PSC_W-1:0]    watchdogPrescale;
   logic [PC_W-1:0]     pc_ff, stackHead_ff;
   int                  err_total = 0;   // mismatches seen
   int                  num_checks = 0;  // comparisons made
   always #12.5 clk_sys = ~clk_sys;
   cie_exec i_cie_exec (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .insnValid(insnValid),
      .insn(insn), .insnAddr(insnAddr), .pcUpper(pcUpper), .wdogTick(wdogTick),
      .fileWrEn_ff(fileWrEn_ff), .fileWrAddr_ff(fileWrAddr_ff), .fileWrData_ff(fileWrData_ff),
      .acc_ff(acc_ff), .zeroFlag_ff(zeroFlag_ff), .expiryStatusFlag_ff(expiryStatusFlag_ff),
      .sleepEnteredFlag_ff(sleepEnteredFlag_ff), .pc_ff(pc_ff), .stackHead_ff(stackHead_ff),
      .stackPush_ff(stackPush_ff), .stall_ff(stall_ff), .watchdogCounter(watchdogCounter),
      .watchdogPrescale(watchdogPrescale));
   // ----------------------------------------
   // compare and report helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // present one instruction at the falling edge, look one cycle later;
   // valid stays up so back-to-back issues need no gap, idle drops it
   task automatic issue(input logic [INSN_W-1:0] word, input logic [PC_W-1:0] addr);
      insn = word;
      insnAddr = addr;
      insnValid = 1'b1;
      @(negedge clk_sys);
   endtask : issue
   // drop valid and let one edge pass with nothing offered
   task automatic idle;
      insnValid = 1'b0;
      @(negedge clk_sys);
   endtask : idle
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   // file clear at both ends of the address range, then frozen by clkEn
   task automatic test_file_clear;
      logic [6:0] adr [2] = '{7'h00, 7'h7f};
      foreach (adr[i]) begin
         issue({OP_FCLR_HI, adr[i]}, 13'h0010);
         check("wr_en", fileWrEn_ff, 1'b1);
         check("wr_addr", fileWrAddr_ff, adr[i]);
         check("wr_data", fileWrData_ff, 8'h00);
         check("zero", zeroFlag_ff, 1'b1);
         check("expiry", expiryStatusFlag_ff, 1'b1);
         check("pc", pc_ff, 13'h0011);
      end
      clkEn = 1'b0;
      issue({OP_FCLR_HI, 7'h22}, 13'h0020);
      check("frozen_en", fileWrEn_ff, 1'b1);
      check("frozen_addr", fileWrAddr_ff, 7'h7f);
      check("frozen_pc", pc_ff, 13'h0011);
      clkEn = 1'b1;
      idle();
      check("wr_end", fileWrEn_ff, 1'b0);
      $display("file clear test done");
   endtask : test_file_clear
   // mid-run reset clears zero, then the accumulator clear must set it
   task automatic test_acc_clear;
      rst = 1'b1;
      @(negedge clk_sys);
      rst = 1'b0;
      check("rst2_zero", zeroFlag_ff, 1'b0);
      issue(OP_ACC_CLEAR, 13'h0030);
      check("acc", acc_ff, 8'h00);
      check("zero", zeroFlag_ff, 1'b1);
      check("no_wr", fileWrEn_ff, 1'b0);
      check("acc_pc", pc_ff, 13'h0031);
      idle();
      $display("accumulator clear test done");
   endtask : test_acc_clear
   // run the time base past one prescaler wrap, then clear with a tick
   task automatic test_wdog_clear;
      wdogTick = 1'b1;
      repeat (260) @(negedge clk_sys);
      check("wd_cnt_run", watchdogCounter, 8'h01);
      check("wd_psc_run", watchdogPrescale, 8'h04);
      issue(OP_WDOG_CLEAR, 13'h0040);
      wdogTick = 1'b0;
      check("wd_cnt", watchdogCounter, 8'h00);
      check("wd_psc", watchdogPrescale, 8'h00);
      check("expiry", expiryStatusFlag_ff, 1'b1);
      check("sleep", sleepEnteredFlag_ff, 1'b1);
      idle();
      $display("watchdog clear test done");
   endtask : test_wdog_clear
   // call, with a file clear offered in its dead cycle
   task automatic test_call;
      pcUpper = 2'h2;
      issue({OP_CALL_HI, 11'h123}, 13'h00a0);
      check("call_pc", pc_ff, {2'h2, 11'h123});
      check("tos", stackHead_ff, 13'h00a1);
      check("push", stackPush_ff, 1'b1);
      check("stall", stall_ff, 1'b1);
      issue({OP_FCLR_HI, 7'h11}, 13'h00a1);
      check("stall_end", stall_ff, 1'b0);
      check("push_end", stackPush_ff, 1'b0);
      check("refused", fileWrEn_ff, 1'b0);
      // the held file clear is taken once the dead cycle is over
      @(negedge clk_sys);
      check("taken_en", fileWrEn_ff, 1'b1);
      check("taken_addr", fileWrAddr_ff, 7'h11);
      check("pc_after", pc_ff, 13'h00a2);
      idle();
      $display("call test done");
   endtask : test_call
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      check("rst_expiry", expiryStatusFlag_ff, 1'b1);
      check("rst_zero", zeroFlag_ff, 1'b0);
      test_file_clear();
      test_acc_clear();
      test_wdog_clear();
      test_call();
      print_verdict();
   end
   initial begin
      #50000;
      err_total++;
      print_verdict();
   end
endmodule : test_clear_instruction_execute
`default_nettype wire
